// >>> qdsl_pkg.sv
// constants shared by the quad converter serial load control block
`default_nettype none

package qdsl_pkg;

  // default converter resolution; the narrow variant uses 10
  localparam int DATA_W_DEF = 12;
  // control bits ahead of the data field: two shutdown bits, two address bits
  localparam int CTRL_W = 4;
  // number of converter channels
  localparam int CHAN_N = 4;
  // channel address width
  localparam int ADDR_W = 2;
  // synchroniser depth for pin inputs
  localparam int SYNC_STAGES = 2;
  // bit positions counted down from the word's top bit
  localparam int OFS_EVERY = 1;
  localparam int OFS_ONE = 2;
  localparam int OFS_ADDR_HI = 3;
  localparam int OFS_ADDR_LO = 4;
  // idle levels of the synchronised pins: clock low, select high, data low, strobe high
  localparam int PIN_N = 4;
  localparam logic [PIN_N-1:0] PIN_IDLE = 4'h5;
  // positions of the pins in the synchroniser vector
  localparam int PIN_SCLK = 3;
  localparam int PIN_CS_N = 2;
  localparam int PIN_SDI = 1;
  localparam int PIN_LOAD_N = 0;

endpackage : qdsl_pkg

`default_nettype wire

// >>> qdsl_sync.sv
// two-flop synchroniser for a vector of pin inputs
`timescale 1ns/1ps
`default_nettype none

module qdsl_sync #(
  parameter int WIDTH = 4,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_reset,
  // raw pins and their synchronised copies
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);

  // both stages of the synchroniser
  typedef struct packed {
    logic [WIDTH-1:0] meta; // first stage, read only by the second
    logic [WIDTH-1:0] safe; // second stage, free for any logic
  } qdsl_sync_s;

  qdsl_sync_s state_q;
  qdsl_sync_s state_d;

  // next value: shift the pins through both stages
  always_comb
  begin
    state_d = state_q;
    state_d.meta = i_async;
    state_d.safe = state_q.meta;
  end

  // register the stages, idle levels at reset
  always_ff @(posedge i_clk_sys or posedge i_reset)
  begin
    if (i_reset)
    begin
      state_q <= {RST_VAL, RST_VAL};
    end
    else
    begin
      state_q <= state_d;
    end
  end

  assign o_sync = state_q.safe;

endmodule : qdsl_sync

`default_nettype wire

// >>> qdsl_ctrl.sv
// serial load and double-buffered register control of a four-channel converter
`timescale 1ns/1ps
`default_nettype none

module qdsl_ctrl #(
  parameter int DATA_W = qdsl_pkg::DATA_W_DEF
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_reset,
  // serial link from the host
  input wire logic i_sclk,
  input wire logic i_cs_n,
  input wire logic i_serial_data_in,
  // strobes
  input wire logic i_output_load_strobe_n,
  input wire logic i_register_clear_n,
  // register contents
  output logic [qdsl_pkg::CHAN_N-1:0][DATA_W-1:0] o_input_reg,
  output logic [qdsl_pkg::CHAN_N-1:0][DATA_W-1:0] o_converter_reg,
  // codes seen by the output amplifiers and their power state
  output logic [qdsl_pkg::CHAN_N-1:0][DATA_W-1:0] o_output_code,
  output logic [qdsl_pkg::CHAN_N-1:0] o_channel_shutdown
);

  // serial word width for this resolution
  localparam int WORD_W = DATA_W + qdsl_pkg::CTRL_W;
  localparam int POS_EVERY = WORD_W - qdsl_pkg::OFS_EVERY;
  localparam int POS_ONE = WORD_W - qdsl_pkg::OFS_ONE;
  localparam int POS_AHI = WORD_W - qdsl_pkg::OFS_ADDR_HI;
  localparam int POS_ALO = WORD_W - qdsl_pkg::OFS_ADDR_LO;

  // link-side state: edge history and shift register
  typedef struct packed {
    logic sclk_prev;         // clock level one cycle ago
    logic cs_n_prev;         // select level one cycle ago
    logic [WORD_W-1:0] shift; // serial shift register
  } qdsl_link_s;

  // register bank, zeroed by reset or by the clear pin
  typedef struct packed {
    logic [qdsl_pkg::CHAN_N-1:0][DATA_W-1:0] inreg; // input registers
    logic [qdsl_pkg::CHAN_N-1:0][DATA_W-1:0] conv;  // converter registers
    logic [qdsl_pkg::CHAN_N-1:0][DATA_W-1:0] outc;  // code driving each amplifier
    logic [qdsl_pkg::CHAN_N-1:0] shut;              // per-channel shutdown
  } qdsl_bank_s;

  qdsl_link_s link_q;
  qdsl_link_s link_d;
  qdsl_bank_s bank_q;
  qdsl_bank_s bank_d;

  logic [qdsl_pkg::PIN_N-1:0] pins_s; // synchronised pins
  logic sclk_s;                       // synchronised serial clock
  logic cs_n_s;                       // synchronised chip select
  logic sdi_s;                        // synchronised serial data
  logic load_n_s;                     // synchronised load strobe
  logic shift_en;                     // clock rise seen while selected
  logic commit;                       // select rise seen
  logic [qdsl_pkg::ADDR_W-1:0] addr;  // channel address of the held word
  logic bank_arst;                    // async reset of the register bank
  logic [DATA_W-1:0] word_data;       // data field of the held word
  logic [WORD_W-2:0] shift_keep;      // shift bits that survive one more shift

  // link pins and load strobe come from the host's domain, two flops before use
  qdsl_sync #(
    .WIDTH(qdsl_pkg::PIN_N),
    .RST_VAL(qdsl_pkg::PIN_IDLE)
  ) u_pin_sync (
    .i_clk_sys(i_clk_sys),
    .i_reset(i_reset),
    .i_async({i_sclk, i_cs_n, i_serial_data_in, i_output_load_strobe_n}),
    .o_sync(pins_s)
  );

  assign sclk_s = pins_s[qdsl_pkg::PIN_SCLK];
  assign cs_n_s = pins_s[qdsl_pkg::PIN_CS_N];
  assign sdi_s = pins_s[qdsl_pkg::PIN_SDI];
  assign load_n_s = pins_s[qdsl_pkg::PIN_LOAD_N];

  // edge detection on the synchronised link
  assign shift_en = ~cs_n_s & sclk_s & ~link_q.sclk_prev;
  assign commit = cs_n_s & ~link_q.cs_n_prev;
  assign addr = {link_q.shift[POS_AHI], link_q.shift[POS_ALO]};
  // named slices of the shift register, watched by the checks below
  assign word_data = link_q.shift[DATA_W-1:0];
  assign shift_keep = link_q.shift[WORD_W-2:0];

  // clear acts without any clock; the shift register is outside its reach
  assign bank_arst = i_reset | ~i_register_clear_n;

  // link next state: shift msb first, older bits fall off the top
  always_comb
  begin
    link_d = link_q;
    link_d.sclk_prev = sclk_s;
    link_d.cs_n_prev = cs_n_s;
    // only a selected clock rise moves the shift register
    if (shift_en)
    begin
      link_d.shift = {link_q.shift[WORD_W-2:0], sdi_s};
    end
  end

  // link registers, reset only by the block reset
  always_ff @(posedge i_clk_sys or posedge i_reset)
  begin
    if (i_reset)
    begin
      // history starts at the idle levels so no false edge follows reset
      link_q <= '{sclk_prev: 1'b0, cs_n_prev: 1'b1, shift: '0};
    end
    else
    begin
      link_q <= link_d;
    end
  end

  // bank next state: decode the committed word, load strobe, output codes
  always_comb
  begin
    bank_d = bank_q;
    // committed word is decoded on the select rise only
    if (commit)
    begin
      if (link_q.shift[POS_EVERY])
      begin
        bank_d.shut = '1;
      end
      else if (link_q.shift[POS_ONE])
      begin
        bank_d.shut[addr] = 1'b1;
      end
      else
      begin
        // plain word: load the addressed input register and wake it
        bank_d.inreg[addr] = link_q.shift[DATA_W-1:0];
        bank_d.shut[addr] = 1'b0;
      end
    end
    // strobe low: converters follow inputs, whatever select does
    if (!load_n_s)
    begin
      bank_d.conv = bank_q.inreg;
    end
    // amplifiers of live channels follow their converter registers
    for (int ch = 0; ch < qdsl_pkg::CHAN_N; ch++)
    begin
      if (!bank_q.shut[ch])
      begin
        bank_d.outc[ch] = bank_q.conv[ch];
      end
    end
  end

  // bank registers: zero at power-on and on clear
  always_ff @(posedge i_clk_sys or posedge bank_arst)
  begin
    if (bank_arst)
    begin
      bank_q <= '0;
    end
    else
    begin
      bank_q <= bank_d;
    end
  end

  // outputs straight from flops
  assign o_input_reg = bank_q.inreg;
  assign o_converter_reg = bank_q.conv;
  assign o_output_code = bank_q.outc;
  assign o_channel_shutdown = bank_q.shut;

  // checks on the bank and the shift register; clear and shift checks pause only in reset, the others while the bank is held clear
  load_copy_a: assert property (@(posedge i_clk_sys) disable iff (bank_arst)
    !load_n_s |=> (o_converter_reg == $past(o_input_reg)))
    else $error("converter registers did not follow input registers");

  load_hold_a: assert property (@(posedge i_clk_sys) disable iff (bank_arst)
    load_n_s |=> $stable(o_converter_reg))
    else $error("converter registers moved after strobe release");

  clear_zero_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    !i_register_clear_n |-> (o_input_reg == '0 && o_converter_reg == '0))
    else $error("clear did not zero the registers");

  clear_keep_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (!i_register_clear_n && cs_n_s) |=> $stable(link_q.shift))
    else $error("clear disturbed the shift register");

  idle_shift_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    cs_n_s |=> $stable(link_q.shift))
    else $error("shift register moved while deselected");

  commit_word_a: assert property (@(posedge i_clk_sys) disable iff (bank_arst)
    (commit && !link_q.shift[POS_EVERY] && !link_q.shift[POS_ONE])
    |=> (o_input_reg[$past(addr)] == $past(word_data)))
    else $error("select rise did not load the addressed input register");

  shift_in_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    shift_en |=> (link_q.shift == {$past(shift_keep), $past(sdi_s)}))
    else $error("clock rise did not shift in the data bit");

  shift_quiet_a: assert property (@(posedge i_clk_sys) disable iff (bank_arst)
    (!commit && load_n_s) |=> ($stable(o_input_reg) && $stable(o_converter_reg)))
    else $error("registers changed without commit or strobe");

  every_off_a: assert property (@(posedge i_clk_sys) disable iff (bank_arst)
    (commit && link_q.shift[POS_EVERY]) |=> (o_channel_shutdown == '1))
    else $error("shutdown-all word left a channel running");

  // frozen outputs per channel while shut down
  for (genvar g = 0; g < qdsl_pkg::CHAN_N; g++)
  begin : g_hold
    out_freeze_a: assert property (@(posedge i_clk_sys) disable iff (bank_arst)
      o_channel_shutdown[g] |=> $stable(o_output_code[g]))
      else $error("shut-down channel output code changed");
  end

  // main scenarios
  commit_c: cover property (@(posedge i_clk_sys) disable iff (bank_arst)
    commit && !link_q.shift[POS_EVERY] && !link_q.shift[POS_ONE]);
  load_c: cover property (@(posedge i_clk_sys) disable iff (bank_arst) !load_n_s && !cs_n_s);
  shutall_c: cover property (@(posedge i_clk_sys) disable iff (bank_arst)
    commit && link_q.shift[POS_EVERY]);
  clear_c: cover property (@(posedge i_clk_sys) disable iff (i_reset) !i_register_clear_n);

endmodule : qdsl_ctrl

`default_nettype wire

// >>> qdsl_host.sv
// host model that drives the serial link of the converter block
`timescale 1ns/1ps
`default_nettype none

module qdsl_host (
  // system clock paces the host
  input wire logic i_clk_sys,
  // serial link pins
  output logic o_sclk,
  output logic o_cs_n,
  output logic o_sdi
);
  // half period of the link clock in system cycles, 80 ns period
  localparam int HALF = 4;
  // link idles with clock still, select high
  initial
  begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_sdi = 1'b0;
  end
  // wait n system edges, then step just past the edge
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk_sys);
    #1;
  endtask : tick
  // one frame of n bits, top bit first; sel low keeps select high throughout
  task automatic frame(input logic [31:0] w, input int n, input logic sel);
    tick(1);
    o_cs_n = ~sel;
    for (int i = n - 1; i >= 0; i--)
    begin
      o_sdi = w[i]; // msb first, set while clock is low
      tick(HALF);
      o_sclk = 1'b1; // rising edge shifts the bit
      tick(HALF);
      o_sclk = 1'b0;
    end
    tick(HALF);
    o_sdi = ~o_sdi; // data line does not keep its last level
    o_cs_n = 1'b1; // select rise commits the word
    tick(HALF);
  endtask : frame
endmodule : qdsl_host

`default_nettype wire

// >>> qdsl_ctrl_tb_top.sv
// self-checking bench for the serial load control block
`timescale 1ns/1ps
`default_nettype none

module qdsl_ctrl_tb_top;
  localparam int W = 12;
  // resolution of the narrow variant, fourteen-bit words
  localparam int NW = 10;
  // clock, reset and strobes
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic load_n = 1'b1;
  logic clr_n = 1'b1;
  // link pins from the host model
  wire logic sclk;
  wire logic cs_n;
  wire logic serial_data_in;
  // design outputs and their expected values
  logic [3:0][W-1:0] in_reg, cv_reg, oc, e_in, e_cv, e_oc;
  logic [3:0] sd, e_sd;
  // input registers of the narrow variant
  logic [3:0][NW-1:0] n_in;
  int mismatches = 0;
  int checked = 0;
  int cycles = 0;

  qdsl_host qdsl_host_inst (.i_clk_sys(clk), .o_sclk(sclk), .o_cs_n(cs_n), .o_sdi(serial_data_in));
  qdsl_ctrl #(.DATA_W(W)) qdsl_ctrl_inst (.i_clk_sys(clk), .i_reset(reset), .i_sclk(sclk),
    .i_cs_n(cs_n), .i_serial_data_in(serial_data_in), .i_output_load_strobe_n(load_n),
    .i_register_clear_n(clr_n), .o_input_reg(in_reg), .o_converter_reg(cv_reg),
    .o_output_code(oc), .o_channel_shutdown(sd));
  // narrow variant listens to the same link and strobes
  if (NW > 0)
  begin : g_narrow
    qdsl_ctrl #(.DATA_W(NW)) qdsl_ctrl_inst (.i_clk_sys(clk), .i_reset(reset), .i_sclk(sclk),
      .i_cs_n(cs_n), .i_serial_data_in(serial_data_in), .i_output_load_strobe_n(load_n),
      .i_register_clear_n(clr_n), .o_input_reg(n_in), .o_converter_reg(),
      .o_output_code(), .o_channel_shutdown());
  end

  // 100 MHz system clock
  always #5 clk = ~clk;
  // hang guard
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      results();
    end
  end

  // compare one value with its expectation
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // let the pipeline settle, then live channels follow their converters
  task automatic settle();
    repeat (6) @(posedge clk);
    #1;
    for (int i = 0; i < 4; i++)
      if (!e_sd[i]) e_oc[i] = e_cv[i];
  endtask : settle
  // compare every output group
  task automatic chk_all();
    chk(in_reg, e_in);
    chk(cv_reg, e_cv);
    chk(oc, e_oc);
    chk({44'h0, sd}, {44'h0, e_sd});
  endtask : chk_all
  // plain data word to one channel; wakes that channel
  task automatic wr(input logic [1:0] a, input logic [W-1:0] d);
    qdsl_host_inst.frame({16'h0, 2'b00, a, d}, 16, 1'b1);
    e_in[a] = d;
    e_sd[a] = 1'b0;
    settle();
  endtask : wr
  // load strobe low for three system cycles
  task automatic pulse_load();
    @(posedge clk);
    #1 load_n = 1'b0;
    repeat (3) @(posedge clk);
    #1 load_n = 1'b1;
  endtask : pulse_load
  // verdict and end of run
  task automatic results();
    $display("mismatches %0d checked %0d", mismatches, checked);
    if (mismatches == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : results

  initial
  begin
    {e_in, e_cv, e_oc, e_sd} = '0;
    repeat (6) @(posedge clk);
    #1 reset = 1'b0;
    repeat (3) @(posedge clk);
    #1;
    chk_all();
    // each address reaches its own channel, converters untouched
    for (int ch = 0; ch < 4; ch++)
    begin
      wr(2'(ch), 12'(12'h3C0 + 12'h111 * ch));
      chk_all();
    end
    // link activity with select high, then an empty frame re-commits the last word
    qdsl_host_inst.frame(32'h0000_5A5A, 16, 1'b0);
    qdsl_host_inst.frame(32'h0, 0, 1'b1);
    settle();
    chk_all();
    // twenty bits: only the last sixteen count
    qdsl_host_inst.frame(32'h000F_1ABC, 20, 1'b1);
    e_in[1] = 12'hABC;
    settle();
    chk_all();
    // strobe while a frame holds select low
    fork
      qdsl_host_inst.frame(32'h0000_2777, 16, 1'b1);
      begin
        repeat (30) @(posedge clk);
        pulse_load();
        e_cv = e_in;
      end
    join
    e_in[2] = 12'h777;
    settle();
    chk_all();
    // shutdown of channel B only, input registers kept
    qdsl_host_inst.frame(32'h0000_5FFF, 16, 1'b1);
    e_sd[1] = 1'b1;
    settle();
    chk_all();
    // shutdown of all, writes still land, outputs frozen except re-woken channel 3
    qdsl_host_inst.frame(32'h0000_8123, 16, 1'b1);
    e_sd = 4'hF;
    settle();
    wr(2'd0, 12'h0F0);
    wr(2'd3, 12'h9C3);
    e_sd[0] = 1'b1;
    qdsl_host_inst.frame(32'h0000_4000, 16, 1'b1);
    settle();
    pulse_load();
    e_cv = e_in;
    settle();
    chk_all();
    // clear acts at once, shift register survives
    @(posedge clk);
    #1 clr_n = 1'b0;
    #2;
    {e_in, e_cv, e_oc, e_sd} = '0;
    chk_all();
    @(posedge clk);
    #1 clr_n = 1'b1;
    qdsl_host_inst.frame(32'h0, 0, 1'b1);
    // the kept shift word still asks for channel A shutdown
    e_sd[0] = 1'b1;
    settle();
    chk_all();
    // fourteen-bit word: narrow variant decodes it, wide keeps two older zero bits above it
    qdsl_host_inst.frame(32'h0000_0AA5, 14, 1'b1);
    e_in[0] = 12'hAA5;
    e_sd[0] = 1'b0;
    settle();
    chk_all();
    chk({8'h0, n_in}, {18'h0, 10'h2A5, 20'h0});
    results();
  end
endmodule : qdsl_ctrl_tb_top

`default_nettype wire
